// >>> logic/reset_cause_pkg.sv
// Constants for the reset-cause flag block: register offsets,
// bit positions and values after reset.
// Assumes a byte-wide register port with 12-bit addresses.

package reset_cause_pkg;

  // ****************************************************
  // Register port
  // ****************************************************
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_BO_CTRL = 12'h191;
  localparam logic [11:0] ADDR_CAUSE = 12'h192;
  localparam logic [11:0] ADDR_CAUSE_EXT = 12'h193;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h194;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h195;

  // ****************************************************
  // Bit positions
  // ****************************************************
  localparam int BIT_STK_OVF = 7;
  localparam int BIT_STK_UNF = 6;
  localparam int BIT_EVT_MEM_VIOL = 5;
  localparam int BIT_WDT = 4;
  localparam int BIT_CLR_PIN = 3;
  localparam int BIT_RST_INSTR = 2;
  localparam int BIT_POWER_ON = 1;
  localparam int BIT_BROWNOUT = 0;
  localparam int BIT_MEM_VIOL = 1;
  localparam int BIT_SOFT_BO_EN = 7;
  localparam int BIT_BO_READY = 0;

  // ****************************************************
  // Masks and values after reset
  // ****************************************************
  localparam logic [7:0] CAUSE_WR_MASK = 8'hDF;
  localparam logic [7:0] CAUSE_PO_RST = 8'h1D;
  localparam logic [7:0] CAUSE_BO_RST = 8'h1C;
  localparam logic EXT_PO_RST = 1'b1;
  localparam logic SOFT_BO_EN_RST = 1'b1;
  localparam logic [7:0] STATUS_PO_RST = 8'h02;
  localparam logic [7:0] MASK_PO_RST = 8'h00;
  localparam logic [7:0] RDATA_IDLE = 8'h00;

endpackage

// >>> logic/level_sync.sv
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes the level is held for several clock cycles.
`timescale 1ns/10ps
`default_nettype none

module level_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Level in and out
  input wire logic d_async,
  output logic q_sync
);

  logic stage1_ff;
  logic stage2_ff;

  // ****************************************************
  // Two stages; only the second reads the first
  // ****************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1_ff <= 1'b0;
      stage2_ff <= 1'b0;
    end else begin
      stage1_ff <= d_async;
      stage2_ff <= stage1_ff;
    end
  end

  assign q_sync = stage2_ff;

endmodule
`default_nettype wire

// >>> logic/reset_cause_flags.sv
// Reset-cause flag registers with brown-out control and event interrupt.
// Assumes reset-cause pulses come from logic on CLK_SYS, one cycle each;
// RST is the power-on reset. BROWNOUT_ARMED is an analog status level.
//
// Overview of operation
// - Power-on reset drives the power-on flag to 0.
// - Power-on or brown-out leaves power-on flag 0; others leave it alone.
// - Power-on flag reads 1 until a power-on or brown-out reset; written 1 is held.
// - Brown-out reset drives brown-out flag, bit 0, to 0.
// - Brown-out flag value after power-on/brown-out depends on the cause.
// - Brown-out flag reads 1 until a brown-out reset; written 1 is held.
// - Memory violation reset drives the memory violation flag to 0.
// - Memory violation flag is bit 1 of second register, 1 after POR/BOR.
// - Memory violation flag reads 1 until such a reset; written 1 is held.
// - Second flag register sits at 0x0193, eight bits, only bit 1 used.
// - Each reset but power-on and brown-out updates only its own flag; both of those reload all flags.
// - Software may write any flag active; the write starts no reset.
// - Stack flags set to 1; watchdog, pin, instruction flags cleared.
// - Brown-out control: soft enable in bit 7, read-only ready in bit 0.
//
// Strobed register access was decided locally.
`timescale 1ns/10ps
`default_nettype none

module reset_cause_flags (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Register port
  input wire logic [11:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Reset-cause pulses
  input wire logic BROWNOUT_RST,
  input wire logic WATCHDOG_RST,
  input wire logic CLEAR_PIN_RST,
  input wire logic RESET_INSTR,
  input wire logic STACK_OVF_RST,
  input wire logic STACK_UNF_RST,
  input wire logic MEM_VIOL_RST,
  // Brown-out detector
  input wire logic BROWNOUT_ARMED,
  output logic SOFT_BROWNOUT_EN,
  // Interrupt
  output logic IRQ
);

  logic [7:0] cause_ff;
  logic [7:0] nxt_cause;
  logic ext_ff;
  logic nxt_ext;
  logic soft_bo_en_ff;
  logic nxt_soft_bo_en;
  logic [7:0] status_ff;
  logic [7:0] nxt_status;
  logic [7:0] mask_ff;
  logic [7:0] nxt_mask;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic armed_sync;
  logic [7:0] evt_vec;
  logic wr_cause;
  logic wr_ext;
  logic rd_status;

  // ****************************************************
  // Detector status crossing
  // ****************************************************
  level_sync u_armed_sync (
    .clk(CLK_SYS),
    .rst(RST),
    .d_async(BROWNOUT_ARMED),
    .q_sync(armed_sync)
  );

  // Access decode
  assign wr_cause = WR && (ADDR == reset_cause_pkg::ADDR_CAUSE);
  assign wr_ext = WR && (ADDR == reset_cause_pkg::ADDR_CAUSE_EXT);
  assign rd_status = RD && (ADDR == reset_cause_pkg::ADDR_IRQ_STATUS);

  // Events in status layout
  always_comb begin
    evt_vec = 8'h00;
    evt_vec[reset_cause_pkg::BIT_STK_OVF] = STACK_OVF_RST;
    evt_vec[reset_cause_pkg::BIT_STK_UNF] = STACK_UNF_RST;
    evt_vec[reset_cause_pkg::BIT_EVT_MEM_VIOL] = MEM_VIOL_RST;
    evt_vec[reset_cause_pkg::BIT_WDT] = WATCHDOG_RST;
    evt_vec[reset_cause_pkg::BIT_CLR_PIN] = CLEAR_PIN_RST;
    evt_vec[reset_cause_pkg::BIT_RST_INSTR] = RESET_INSTR;
    evt_vec[reset_cause_pkg::BIT_BROWNOUT] = BROWNOUT_RST;
  end

  // ****************************************************
  // Reset-cause flags
  // ****************************************************
  // Software write first, hardware events after so they win
  always_comb begin
    nxt_cause = cause_ff;
    nxt_ext = ext_ff;
    nxt_soft_bo_en = soft_bo_en_ff;
    if (wr_cause) begin
      nxt_cause = WDATA & reset_cause_pkg::CAUSE_WR_MASK;
    end
    if (wr_ext) begin
      nxt_ext = WDATA[reset_cause_pkg::BIT_MEM_VIOL];
    end
    if (WR && (ADDR == reset_cause_pkg::ADDR_BO_CTRL)) begin
      nxt_soft_bo_en = WDATA[reset_cause_pkg::BIT_SOFT_BO_EN];
    end
    if (STACK_OVF_RST) begin
      nxt_cause[reset_cause_pkg::BIT_STK_OVF] = 1'b1;
    end
    if (STACK_UNF_RST) begin
      nxt_cause[reset_cause_pkg::BIT_STK_UNF] = 1'b1;
    end
    if (WATCHDOG_RST) begin
      nxt_cause[reset_cause_pkg::BIT_WDT] = 1'b0;
    end
    if (CLEAR_PIN_RST) begin
      nxt_cause[reset_cause_pkg::BIT_CLR_PIN] = 1'b0;
    end
    if (RESET_INSTR) begin
      nxt_cause[reset_cause_pkg::BIT_RST_INSTR] = 1'b0;
    end
    if (MEM_VIOL_RST) begin
      nxt_ext = 1'b0;
    end
    // Brown-out reinitialises the flags and the soft enable
    if (BROWNOUT_RST) begin
      nxt_cause = reset_cause_pkg::CAUSE_BO_RST;
      nxt_ext = reset_cause_pkg::EXT_PO_RST;
      nxt_soft_bo_en = reset_cause_pkg::SOFT_BO_EN_RST;
    end
  end

  // Flag registers; power-on reset loads its own pattern
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      cause_ff <= reset_cause_pkg::CAUSE_PO_RST;
      ext_ff <= reset_cause_pkg::EXT_PO_RST;
      soft_bo_en_ff <= reset_cause_pkg::SOFT_BO_EN_RST;
    end else begin
      cause_ff <= nxt_cause;
      ext_ff <= nxt_ext;
      soft_bo_en_ff <= nxt_soft_bo_en;
    end
  end

  assign SOFT_BROWNOUT_EN = soft_bo_en_ff;

  // ****************************************************
  // Event status, mask and interrupt
  // ****************************************************
  // Read clears; an event in the same cycle survives
  always_comb begin
    nxt_status = status_ff;
    nxt_mask = mask_ff;
    if (rd_status) begin
      nxt_status = 8'h00;
    end
    nxt_status = nxt_status | evt_vec;
    if (WR && (ADDR == reset_cause_pkg::ADDR_IRQ_MASK)) begin
      nxt_mask = WDATA;
    end
  end

  // Status and mask registers
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      status_ff <= reset_cause_pkg::STATUS_PO_RST;
      mask_ff <= reset_cause_pkg::MASK_PO_RST;
    end else begin
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
    end
  end

  // Level interrupt while any unmasked bit stands
  assign IRQ = |(status_ff & mask_ff);

  // ****************************************************
  // Read data
  // ****************************************************
  // Unmapped and idle cycles return zero
  always_comb begin
    nxt_rdata = reset_cause_pkg::RDATA_IDLE;
    if (RD) begin
      case (ADDR)
        reset_cause_pkg::ADDR_BO_CTRL: begin
          nxt_rdata[reset_cause_pkg::BIT_SOFT_BO_EN] = soft_bo_en_ff;
          nxt_rdata[reset_cause_pkg::BIT_BO_READY] = armed_sync;
        end
        reset_cause_pkg::ADDR_CAUSE: begin
          nxt_rdata = cause_ff & reset_cause_pkg::CAUSE_WR_MASK;
        end
        reset_cause_pkg::ADDR_CAUSE_EXT: begin
          nxt_rdata[reset_cause_pkg::BIT_MEM_VIOL] = ext_ff;
        end
        reset_cause_pkg::ADDR_IRQ_STATUS: begin
          nxt_rdata = status_ff;
        end
        reset_cause_pkg::ADDR_IRQ_MASK: begin
          nxt_rdata = mask_ff;
        end
        default: begin
          nxt_rdata = reset_cause_pkg::RDATA_IDLE;
        end
      endcase
    end
  end

  // Read data register
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rdata_ff <= reset_cause_pkg::RDATA_IDLE;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign RDATA = rdata_ff;

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  sequence s_read_ext;
    RD && (ADDR == reset_cause_pkg::ADDR_CAUSE_EXT);
  endsequence

  sequence s_read_status_quiet;
    rd_status && (evt_vec == 8'h00);
  endsequence

  sequence s_read_bo_ctrl;
    RD && (ADDR == reset_cause_pkg::ADDR_BO_CTRL);
  endsequence

  a_power_on_low: assert property (
    $fell(RST) |-> !cause_ff[reset_cause_pkg::BIT_POWER_ON]
      && cause_ff[reset_cause_pkg::BIT_BROWNOUT] && ext_ff)
    else $error("power-on pattern wrong after reset");

  a_brownout_load: assert property (
    BROWNOUT_RST |=> !cause_ff[reset_cause_pkg::BIT_BROWNOUT]
      && !cause_ff[reset_cause_pkg::BIT_POWER_ON] && ext_ff
      && !cause_ff[reset_cause_pkg::BIT_STK_OVF])
    else $error("brown-out pattern wrong");

  a_power_on_keep: assert property (
    !BROWNOUT_RST && !wr_cause |=>
      $stable(cause_ff[reset_cause_pkg::BIT_POWER_ON]))
    else $error("power-on flag moved without cause");

  a_brownout_keep: assert property (
    !BROWNOUT_RST && !wr_cause |=>
      $stable(cause_ff[reset_cause_pkg::BIT_BROWNOUT]))
    else $error("brown-out flag moved without cause");

  a_soft_write: assert property (
    wr_cause && (evt_vec == 8'h00) && !MEM_VIOL_RST |=>
      cause_ff == ($past(WDATA) & reset_cause_pkg::CAUSE_WR_MASK)
      ##1 ($past(wr_cause) || ($past(evt_vec) != 8'h00)
        || cause_ff == $past(cause_ff)))
    else $error("written flags not held");

  a_mem_clear: assert property (
    MEM_VIOL_RST && !BROWNOUT_RST |=> !ext_ff ##1 RDATA == 8'h00
      || !$past(RD && (ADDR == reset_cause_pkg::ADDR_CAUSE_EXT)))
    else $error("memory violation flag not cleared");

  a_mem_keep: assert property (
    !MEM_VIOL_RST && !BROWNOUT_RST && !wr_ext |=> $stable(ext_ff))
    else $error("memory violation flag moved without cause");

  a_ext_read: assert property (
    s_read_ext |=> RDATA == {6'h00, $past(ext_ff), 1'b0})
    else $error("second flag register read wrong");

  a_stack_set: assert property (
    STACK_OVF_RST && !BROWNOUT_RST && !wr_cause |=>
      cause_ff[reset_cause_pkg::BIT_STK_OVF]
      && status_ff[reset_cause_pkg::BIT_STK_OVF])
    else $error("stack overflow flag not set");

  a_hw_clears: assert property (
    WATCHDOG_RST && !BROWNOUT_RST && !wr_cause |=>
      !cause_ff[reset_cause_pkg::BIT_WDT]
      && cause_ff[reset_cause_pkg::BIT_POWER_ON]
        == $past(cause_ff[reset_cause_pkg::BIT_POWER_ON]))
    else $error("watchdog flag wrong");

  a_soft_no_reset: assert property (
    wr_cause |=> !status_ff[reset_cause_pkg::BIT_BROWNOUT]
      || $past(status_ff[reset_cause_pkg::BIT_BROWNOUT])
      || $past(BROWNOUT_RST))
    else $error("software write raised an event");

  a_bo_ctrl_read: assert property (
    s_read_bo_ctrl |=> RDATA[reset_cause_pkg::BIT_SOFT_BO_EN]
      == $past(soft_bo_en_ff) && RDATA[6:1] == 6'h00)
    else $error("brown-out control read wrong");

  a_status_clear: assert property (
    s_read_status_quiet ##1 !rd_status [*2] |-> status_ff == 8'h00
      || $past(evt_vec) != 8'h00)
    else $error("status not cleared by read");

  a_irq_follows: assert property (
    (status_ff & mask_ff) != 8'h00 |-> IRQ ##1 (IRQ
      || (status_ff & mask_ff) == 8'h00))
    else $error("interrupt level wrong");

endmodule
`default_nettype wire

// >>> testbench/reset_cause_flags_tb.sv
// Self-checking bench for the reset-cause flag block.
// Assumes the package and the block sources are compiled before it.
`timescale 1ns/10ps
`default_nettype none

module reset_cause_flags_tb;
  // ****************************************************
  // Signals
  // ****************************************************
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [11:0] addr = 12'h000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [6:0] cause = 7'h00;
  logic armed = 1'b0;
  logic soft_en;
  logic irq;
  int err_count = 0;
  int n_tests = 0;
  int seed;
  logic [7:0] got, mask, base, ext, ctl;

  // Design under test
  reset_cause_flags u_dut (
    .CLK_SYS(clk_sys), .RST(rst), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata),
    .BROWNOUT_RST(cause[0]), .WATCHDOG_RST(cause[1]),
    .CLEAR_PIN_RST(cause[2]), .RESET_INSTR(cause[3]),
    .STACK_OVF_RST(cause[4]), .STACK_UNF_RST(cause[5]),
    .MEM_VIOL_RST(cause[6]), .BROWNOUT_ARMED(armed),
    .SOFT_BROWNOUT_EN(soft_en), .IRQ(irq)
  );

  // 100 MHz clock
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  // ****************************************************
  // Bus, pulse and compare tasks
  // ****************************************************
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // One-cycle pulse on one cause input
  task automatic fire(input int idx);
    @(posedge clk_sys);
    cause <= 7'h01 << idx;
    @(posedge clk_sys);
    cause <= 7'h00;
    #1;
  endtask

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic s);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %b seen %b", nm, e, s);
    end
  endtask

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ****************************************************
  // Expectation functions
  // ****************************************************
  // Event-status layout bit for each pulse index
  function automatic logic [7:0] bit_of(input int idx);
    case (idx)
      0: return 8'h01 << reset_cause_pkg::BIT_BROWNOUT;
      1: return 8'h01 << reset_cause_pkg::BIT_WDT;
      2: return 8'h01 << reset_cause_pkg::BIT_CLR_PIN;
      3: return 8'h01 << reset_cause_pkg::BIT_RST_INSTR;
      4: return 8'h01 << reset_cause_pkg::BIT_STK_OVF;
      5: return 8'h01 << reset_cause_pkg::BIT_STK_UNF;
      default: return 8'h01 << reset_cause_pkg::BIT_EVT_MEM_VIOL;
    endcase
  endfunction

  // Flag byte after one event; stack flags set, watchdog, pin, instruction cleared, brown-out reloads 1C, memory violation leaves it
  function automatic logic [7:0] exp_flags(input int idx, input logic [7:0] cur);
    case (idx)
      0: return 8'h1C;
      4, 5: return cur | bit_of(idx);
      6: return cur;
      default: return cur & ~bit_of(idx);
    endcase
  endfunction

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    seed = $urandom(76);
    armed <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    // Values after power-on
    rd_reg(reset_cause_pkg::ADDR_CAUSE, got);
    chk8("cause_po", 8'h1D, got);
    rd_reg(reset_cause_pkg::ADDR_CAUSE_EXT, got);
    chk8("ext_po", 8'h02, got);
    rd_reg(reset_cause_pkg::ADDR_BO_CTRL, got);
    chk8("bo_ctrl_po", 8'h81, got);
    rd_reg(reset_cause_pkg::ADDR_IRQ_STATUS, got);
    chk8("status_po", 8'h02, got);
    rd_reg(reset_cause_pkg::ADDR_IRQ_STATUS, got);
    chk8("status_clr", 8'h00, got);
    // Firmware writes ones: held, no event raised
    wr_reg(reset_cause_pkg::ADDR_CAUSE, 8'hFF);
    wr_reg(reset_cause_pkg::ADDR_CAUSE_EXT, 8'hFF);
    rd_reg(reset_cause_pkg::ADDR_CAUSE, got);
    chk8("cause_ones", 8'hDF, got);
    rd_reg(reset_cause_pkg::ADDR_CAUSE_EXT, got);
    chk8("ext_ones", 8'h02, got);
    rd_reg(reset_cause_pkg::ADDR_IRQ_STATUS, got);
    chk8("status_wr", 8'h00, got);
    // Power-on reset in mid-run over firmware ones
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd_reg(reset_cause_pkg::ADDR_CAUSE, got);
    chk8("cause_rerst", 8'h1D, got);
    rd_reg(reset_cause_pkg::ADDR_IRQ_STATUS, got);
    chk8("status_rerst", 8'h02, got);
    // Corner: watchdog event beside a firmware write of ones
    @(posedge clk_sys);
    addr <= reset_cause_pkg::ADDR_CAUSE;
    wdata <= 8'hFF;
    wr <= 1'b1;
    cause <= 7'h02;
    @(posedge clk_sys);
    wr <= 1'b0;
    cause <= 7'h00;
    #1;
    rd_reg(reset_cause_pkg::ADDR_CAUSE, got);
    chk8("cause_wr_evt", 8'hCF, got);
    // Corner: clear-pin event beside a status read
    @(posedge clk_sys);
    addr <= reset_cause_pkg::ADDR_IRQ_STATUS;
    rd <= 1'b1;
    cause <= 7'h04;
    @(posedge clk_sys);
    rd <= 1'b0;
    cause <= 7'h00;
    #1;
    chk8("status_rd_evt", 8'h10, rdata);
    rd_reg(reset_cause_pkg::ADDR_IRQ_STATUS, got);
    chk8("status_keep", 8'h08, got);
    // Unmapped places
    wr_reg(12'h196, 8'hFF);
    rd_reg(12'h196, got);
    chk8("unmapped_hi", 8'h00, got);
    rd_reg(12'h190, got);
    chk8("unmapped_lo", 8'h00, got);
    @(posedge clk_sys);
    #1;
    chk8("rdata_idle", 8'h00, rdata);
    // Every cause, random starting values
    for (int r = 0; r < 4; r++) begin
      for (int idx = 0; idx < 7; idx++) begin
        mask = 8'($urandom);
        ctl = 8'($urandom);
        base = 8'($urandom) & reset_cause_pkg::CAUSE_WR_MASK;
        ext = 8'($urandom) & 8'h02;
        armed <= mask[3];
        wr_reg(reset_cause_pkg::ADDR_IRQ_MASK, mask);
        wr_reg(reset_cause_pkg::ADDR_BO_CTRL, ctl);
        chk1("soft_en_wr", ctl[7], soft_en);
        wr_reg(reset_cause_pkg::ADDR_CAUSE, base);
        wr_reg(reset_cause_pkg::ADDR_CAUSE_EXT, ext);
        fire(idx);
        chk1("irq_set", |(mask & bit_of(idx)), irq);
        rd_reg(reset_cause_pkg::ADDR_CAUSE, got);
        chk8("cause", exp_flags(idx, base), got);
        rd_reg(reset_cause_pkg::ADDR_CAUSE_EXT, got);
        chk8("ext", (idx == 0) ? 8'h02 : ((idx == 6) ? 8'h00 : ext), got);
        rd_reg(reset_cause_pkg::ADDR_BO_CTRL, got);
        chk8("bo_ctrl", {(idx == 0) | ctl[7], 6'h00, armed}, got);
        chk1("soft_en", (idx == 0) | ctl[7], soft_en);
        rd_reg(reset_cause_pkg::ADDR_IRQ_STATUS, got);
        chk8("status", bit_of(idx), got);
        chk1("irq_clr", 1'b0, irq);
      end
    end
    tally_and_finish();
  end

  // Watchdog against a hang
  initial begin
    #50000;
    err_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
